// [common/dcs_pkg.sv]
// Constants, register map and state codes of the sequencer
package dcs_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses of 32-bit words)
  // ------------------------------------------------------------
  localparam logic [4:0] OFS_CONTROL = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_GRANT = 5'h08;
  localparam logic [4:0] OFS_BUFFER = 5'h0c;
  localparam logic [4:0] OFS_DISK_ADDR = 5'h10;
  localparam logic [4:0] OFS_TIMER = 5'h14;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CTL_FUNC_LSB = 0;
  localparam int CTL_IE_BIT = 6;
  localparam int CTL_READY_BIT = 7;
  localparam int ST_MATCH_BIT = 0;
  localparam int ST_CRC_ERR_BIT = 1;
  localparam int ST_XFER_REQ_BIT = 2;
  localparam int ST_BUF_SEL_BIT = 3;
  localparam int ST_BR5_BIT = 4;
  localparam int ST_READY_BIT = 5;
  localparam int ST_STATE_LSB = 8;
  localparam int BUF_SEL_BIT = 16;
  localparam int BUF_ADDR_LSB = 8;

  // ------------------------------------------------------------
  // Reset values and function codes
  // ------------------------------------------------------------
  localparam logic RST_READY = 1'b1;
  localparam logic [15:0] RST_CRC = 16'h0000;
  localparam logic [15:0] CRC_POLY = 16'h8005;
  localparam logic [2:0] FN_CART_CHECK = 3'h1;
  localparam logic [2:0] FN_FIXED_WRITE = 3'h4;
  localparam logic [2:0] FN_FIXED_READ = 3'h5;
  localparam logic [2:0] FN_FIXED_CHECK = 3'h6;

  // ------------------------------------------------------------
  // Counts
  // ------------------------------------------------------------
  localparam int SECTOR_BYTES = 256;
  localparam int CRC_BITS = 16;
  localparam logic [6:0] GLITCH_PULSES = 7'd60;
  localparam logic [6:0] LOCK_PULSES = 7'd88;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    CK_CPU = 2'b00,
    CK_SERVO = 2'b01,
    CK_SEP = 2'b10,
    CK_STOP = 2'b11
  } dcs_clk_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_FX_RDY = 4'b0001,
    ST_FX_SECT = 4'b0010,
    ST_FX_GAP = 4'b0011,
    ST_FX_LOCK = 4'b0100,
    ST_FX_HDR = 4'b0101,
    ST_WC_SYNC = 4'b0110,
    ST_WC_DATA = 4'b0111,
    ST_WC_CRC = 4'b1000,
    ST_WC_CMP = 4'b1001,
    ST_WC_GRANT = 4'b1010,
    ST_WC_NEXT = 4'b1011,
    ST_WC_DRV = 4'b1100
  } dcs_state_t;

endpackage

// [design/dcs_sequencer.sv]
// Sector write-check and fixed-drive opening sequencer with register port
//
// Behaviour
// - Shift bits 0 to 7 of each byte on the drive-derived clock.
// - After bit 7 load next byte, bump address; 256 bytes.
// - Compare each read bit with the serial output.
// - Each serial output bit feeds a 16-bit CRC over 2048 bits.
// - At buffer full sample compare: low on difference, high on match.
// - Compare result goes to the status word only; the sequencer ignores it.
// - Load the 16-bit drive CRC; flag any disagreement.
// - On the last CRC bit both clock outputs take the CPU phase clock.
// - CRC error: set ready, level-5 request if enabled, idle.
// - A data mismatch alone never ends the check.
// - No CRC error: clear buffer address, raise transfer request.
// - Grant clears request; swap buffer, examine ready.
// - Ready clear: bump disk address, reset timer, await drive, go on.
// - Ready set before grant: set ready, request if enabled, idle.
// - Fixed functions select buffer A, reset address, await drive.
// - Drive ready: both clock outputs take the servo clock.
// - Await sector sync edge from sector or index pulse.
// - Wait 60 servo pulses before the read gate.
// - Read gate raises tag bit 1, tag line 3, control tag.
// - On the same edge clear CRC and compare result; then wait 88 servo pulses.
// - Then preset header search; sync found arms serializer for disk address.
// - Sync search runs current clock only; sequence clock stopped.
// - Write check sync found pulses compare-load for first byte.
`timescale 1ns/1ps
`default_nettype none

module dcs_sequencer #(
  parameter int BYTES = dcs_pkg::SECTOR_BYTES
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Avalon-MM slave
  input wire logic [4:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Drive pins
  input wire logic servo_clock_in,
  input wire logic drive_read_clock_in,
  input wire logic serial_read_stream_in,
  input wire logic drive_sector_pulse_in,
  input wire logic drive_index_pulse_in,
  input wire logic drive_ready_in,
  output logic tag_bus_bit1_out,
  output logic tag_line_three_out,
  output logic control_tag_strobe_out,
  // Header search logic
  input wire logic sync_found_in,
  output logic header_search_preset_out,
  output logic serializer_address_enable_out,
  output logic shift_serial_out,
  output logic compare_load_strobe_out,
  // Clock control
  output logic [1:0] current_clock_sel_out,
  output logic [1:0] sequence_clock_sel_out,
  // CPU port
  output logic port_transfer_request_out,
  output logic bus_request_level5_out
);

  localparam int AW = $clog2(BYTES);

  if (BYTES < 2 || (1 << AW) != BYTES) begin
    $error("BYTES must be a power of two of at least 2");
  end

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic b);
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? dcs_pkg::CRC_POLY : 16'h0000);
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers and edge finding
  // ------------------------------------------------------------
  logic [4:0] sync1_q, sync2_q, prev_q;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
      prev_q <= 5'h00;
    end else begin
      sync1_q <= {drive_ready_in, drive_index_pulse_in, drive_sector_pulse_in,
                  drive_read_clock_in, servo_clock_in};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  logic servo_rise, sep_rise, sector_sync, sector_rise, drv_ready, read_bit_q;
  assign servo_rise = sync2_q[0] & ~prev_q[0];
  assign sep_rise = sync2_q[1] & ~prev_q[1];
  // Sector sync pulse from either the sector or the index pulse
  assign sector_sync = sync2_q[2] | sync2_q[3];
  assign sector_rise = sector_sync & ~(prev_q[2] | prev_q[3]);
  assign drv_ready = sync2_q[4];

  // Data takes the read clock's two-stage path to stay aligned
  logic rd_s1_q;
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_s1_q <= 1'b0;
      read_bit_q <= 1'b0;
    end else begin
      rd_s1_q <= serial_read_stream_in;
      read_bit_q <= rd_s1_q;
    end
  end

  // ------------------------------------------------------------
  // Clock control
  // ------------------------------------------------------------
  dcs_pkg::dcs_clk_t cur_sel_q, seq_sel_q;

  function automatic logic tick_of(input dcs_pkg::dcs_clk_t s,
                                   input logic servo, input logic sep);
    unique case (s)
      dcs_pkg::CK_CPU: tick_of = 1'b1;
      dcs_pkg::CK_SERVO: tick_of = servo;
      dcs_pkg::CK_SEP: tick_of = sep;
      dcs_pkg::CK_STOP: tick_of = 1'b0;
    endcase
  endfunction

  logic cur_tick, seq_tick;
  assign cur_tick = tick_of(cur_sel_q, servo_rise, sep_rise);
  assign seq_tick = tick_of(seq_sel_q, servo_rise, sep_rise);

  // ------------------------------------------------------------
  // Register file state
  // ------------------------------------------------------------
  logic [2:0] func_q;
  logic ie_q, ie_prev_q, ready_q, match_q, crc_err_q, req_q, br5_q;
  logic buf_sel_q;
  logic [15:0] disk_addr_q, timer_q, crc_q, drive_crc_q;
  logic [7:0] buf_mem [2][BYTES];
  logic wait_q, ctl_wr, grant_wr, buf_wr;
  logic [31:0] status_word;

  assign ctl_wr = avs_write_in & ~wait_q &
                  (avs_address_in == dcs_pkg::OFS_CONTROL);
  assign grant_wr = avs_write_in & ~wait_q & avs_writedata_in[0] &
                    (avs_address_in == dcs_pkg::OFS_GRANT);
  assign buf_wr = avs_write_in & ~wait_q &
                  (avs_address_in == dcs_pkg::OFS_BUFFER);

  dcs_pkg::dcs_state_t state_q;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[dcs_pkg::ST_MATCH_BIT] = match_q;
    status_word[dcs_pkg::ST_CRC_ERR_BIT] = crc_err_q;
    status_word[dcs_pkg::ST_XFER_REQ_BIT] = req_q;
    status_word[dcs_pkg::ST_BUF_SEL_BIT] = buf_sel_q;
    status_word[dcs_pkg::ST_BR5_BIT] = br5_q;
    status_word[dcs_pkg::ST_READY_BIT] = ready_q;
    status_word[dcs_pkg::ST_STATE_LSB +: 4] = state_q;
  end

  // ------------------------------------------------------------
  // Avalon slave: one wait state, answer on the second edge
  // ------------------------------------------------------------
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      wait_q <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      wait_q <= ~((avs_read_in | avs_write_in) & wait_q);
      if (avs_read_in & wait_q) begin
        unique case (avs_address_in)
          dcs_pkg::OFS_CONTROL:
            avs_readdata_out <= {24'h000000, ready_q, ie_q, 3'h0, func_q};
          dcs_pkg::OFS_STATUS: avs_readdata_out <= status_word;
          dcs_pkg::OFS_DISK_ADDR: avs_readdata_out <= {16'h0000, disk_addr_q};
          dcs_pkg::OFS_TIMER: avs_readdata_out <= {16'h0000, timer_q};
          default: avs_readdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign avs_waitrequest_out = wait_q;

  // Software fills either buffer half
  always_ff @(posedge mclk_in) begin
    if (buf_wr) begin
      buf_mem[avs_writedata_in[dcs_pkg::BUF_SEL_BIT]]
             [avs_writedata_in[dcs_pkg::BUF_ADDR_LSB +: AW]] <=
        avs_writedata_in[7:0];
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  logic [7:0] shift_q;
  logic [2:0] bit_q;
  logic [AW:0] ptr_q;
  logic [6:0] wait_cnt_q;
  logic [4:0] crc_cnt_q;
  logic diff_q;
  logic is_fixed;
  assign is_fixed = (avs_writedata_in[2:0] == dcs_pkg::FN_FIXED_WRITE) |
                    (avs_writedata_in[2:0] == dcs_pkg::FN_FIXED_READ) |
                    (avs_writedata_in[2:0] == dcs_pkg::FN_FIXED_CHECK);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= dcs_pkg::ST_IDLE;
      cur_sel_q <= dcs_pkg::CK_CPU;
      seq_sel_q <= dcs_pkg::CK_CPU;
      func_q <= 3'h0;
      ie_q <= 1'b0;
      ie_prev_q <= 1'b0;
      ready_q <= dcs_pkg::RST_READY;
      match_q <= 1'b0;
      crc_err_q <= 1'b0;
      req_q <= 1'b0;
      br5_q <= 1'b0;
      buf_sel_q <= 1'b0;
      disk_addr_q <= 16'h0000;
      timer_q <= 16'h0000;
      crc_q <= dcs_pkg::RST_CRC;
      drive_crc_q <= 16'h0000;
      shift_q <= 8'h00;
      bit_q <= 3'h0;
      ptr_q <= '0;
      wait_cnt_q <= 7'h00;
      crc_cnt_q <= 5'h00;
      diff_q <= 1'b0;
      tag_bus_bit1_out <= 1'b0;
      tag_line_three_out <= 1'b0;
      control_tag_strobe_out <= 1'b0;
      header_search_preset_out <= 1'b0;
      serializer_address_enable_out <= 1'b0;
      compare_load_strobe_out <= 1'b0;
    end else begin
      compare_load_strobe_out <= 1'b0;
      serializer_address_enable_out <= 1'b0;
      timer_q <= (state_q == dcs_pkg::ST_IDLE) ? timer_q : timer_q + 16'h0001;
      // A ready set by the sequencer below wins over a software clear
      if (ctl_wr) begin
        ie_q <= avs_writedata_in[dcs_pkg::CTL_IE_BIT];
        ready_q <= avs_writedata_in[dcs_pkg::CTL_READY_BIT];
      end
      if (grant_wr && state_q == dcs_pkg::ST_WC_GRANT) begin
        req_q <= 1'b0;
      end
      unique case (state_q)
        dcs_pkg::ST_IDLE: begin
          if (ctl_wr && !avs_writedata_in[dcs_pkg::CTL_READY_BIT]) begin
            func_q <= avs_writedata_in[dcs_pkg::CTL_FUNC_LSB +: 3];
            ie_prev_q <= avs_writedata_in[dcs_pkg::CTL_IE_BIT];
            br5_q <= 1'b0;
            crc_err_q <= 1'b0;
            crc_q <= dcs_pkg::RST_CRC;
            diff_q <= 1'b0;
            ptr_q <= '0;
            if (is_fixed) begin
              buf_sel_q <= 1'b0;
              state_q <= dcs_pkg::ST_FX_RDY;
            end else if (avs_writedata_in[2:0] == dcs_pkg::FN_CART_CHECK) begin
              cur_sel_q <= dcs_pkg::CK_SEP;
              seq_sel_q <= dcs_pkg::CK_STOP;
              state_q <= dcs_pkg::ST_WC_SYNC;
            end
          end
        end
        dcs_pkg::ST_FX_RDY: begin
          if (drv_ready) begin
            cur_sel_q <= dcs_pkg::CK_SERVO;
            seq_sel_q <= dcs_pkg::CK_SERVO;
            state_q <= dcs_pkg::ST_FX_SECT;
          end
        end
        dcs_pkg::ST_FX_SECT: begin
          wait_cnt_q <= 7'h00;
          if (sector_rise) begin
            state_q <= dcs_pkg::ST_FX_GAP;
          end
        end
        dcs_pkg::ST_FX_GAP: begin
          // Skip the glitchy start of the gap before asking for lock
          if (seq_tick) begin
            if (wait_cnt_q == dcs_pkg::GLITCH_PULSES - 7'd1) begin
              tag_bus_bit1_out <= 1'b1;
              tag_line_three_out <= 1'b1;
              control_tag_strobe_out <= 1'b1;
              crc_q <= dcs_pkg::RST_CRC;
              match_q <= 1'b0;
              wait_cnt_q <= 7'h00;
              state_q <= dcs_pkg::ST_FX_LOCK;
            end else begin
              wait_cnt_q <= wait_cnt_q + 7'd1;
            end
          end
        end
        dcs_pkg::ST_FX_LOCK: begin
          if (seq_tick) begin
            if (wait_cnt_q == dcs_pkg::LOCK_PULSES - 7'd1) begin
              header_search_preset_out <= 1'b1;
              cur_sel_q <= dcs_pkg::CK_SEP;
              seq_sel_q <= dcs_pkg::CK_STOP;
              state_q <= dcs_pkg::ST_FX_HDR;
            end else begin
              wait_cnt_q <= wait_cnt_q + 7'd1;
            end
          end
        end
        dcs_pkg::ST_FX_HDR: begin
          // Stalled until sync; the serializer then takes over
          if (sync_found_in) begin
            seq_sel_q <= dcs_pkg::CK_SEP;
            header_search_preset_out <= 1'b0;
            serializer_address_enable_out <= 1'b1;
            state_q <= dcs_pkg::ST_IDLE;
          end
        end
        dcs_pkg::ST_WC_SYNC: begin
          if (sync_found_in) begin
            seq_sel_q <= dcs_pkg::CK_SEP;
            compare_load_strobe_out <= 1'b1;
            shift_q <= buf_mem[buf_sel_q][ptr_q[AW-1:0]];
            ptr_q <= ptr_q + 1'b1;
            bit_q <= 3'h0;
            diff_q <= 1'b0;
            state_q <= dcs_pkg::ST_WC_DATA;
          end
        end
        dcs_pkg::ST_WC_DATA: begin
          if (cur_tick) begin
            diff_q <= diff_q | (read_bit_q ^ shift_q[0]);
            crc_q <= crc_step(crc_q, shift_q[0]);
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              if (ptr_q[AW]) begin
                // Buffer full: sample the compare result
                match_q <= ~(diff_q | (read_bit_q ^ shift_q[0]));
                crc_cnt_q <= 5'h00;
                state_q <= dcs_pkg::ST_WC_CRC;
              end else begin
                shift_q <= buf_mem[buf_sel_q][ptr_q[AW-1:0]];
                ptr_q <= ptr_q + 1'b1;
              end
            end else begin
              shift_q <= {1'b0, shift_q[7:1]};
            end
          end
        end
        dcs_pkg::ST_WC_CRC: begin
          if (cur_tick) begin
            drive_crc_q <= {drive_crc_q[14:0], read_bit_q};
            crc_cnt_q <= crc_cnt_q + 5'd1;
            if (crc_cnt_q == 5'(dcs_pkg::CRC_BITS - 1)) begin
              cur_sel_q <= dcs_pkg::CK_CPU;
              seq_sel_q <= dcs_pkg::CK_CPU;
              state_q <= dcs_pkg::ST_WC_CMP;
            end
          end
        end
        dcs_pkg::ST_WC_CMP: begin
          // Only the CRC outcome ends the check; the CRC covers buffer bits, so a data miss shows only in match
          if (crc_q != drive_crc_q) begin
            crc_err_q <= 1'b1;
            ready_q <= 1'b1;
            br5_q <= ie_prev_q;
            state_q <= dcs_pkg::ST_IDLE;
          end else begin
            ptr_q <= '0;
            req_q <= 1'b1;
            state_q <= dcs_pkg::ST_WC_GRANT;
          end
        end
        dcs_pkg::ST_WC_GRANT: begin
          if (grant_wr) begin
            buf_sel_q <= ~buf_sel_q;
            state_q <= dcs_pkg::ST_WC_NEXT;
          end
        end
        dcs_pkg::ST_WC_NEXT: begin
          if (ready_q) begin
            ready_q <= 1'b1;
            br5_q <= ie_prev_q;
            state_q <= dcs_pkg::ST_IDLE;
          end else begin
            disk_addr_q <= disk_addr_q + 16'h0001;
            timer_q <= 16'h0000;
            state_q <= dcs_pkg::ST_WC_DRV;
          end
        end
        dcs_pkg::ST_WC_DRV: begin
          if (drv_ready) begin
            crc_q <= dcs_pkg::RST_CRC;
            cur_sel_q <= dcs_pkg::CK_SEP;
            seq_sel_q <= dcs_pkg::CK_STOP;
            state_q <= dcs_pkg::ST_WC_SYNC;
          end
        end
        default: state_q <= dcs_pkg::ST_IDLE;
      endcase
    end
  end

  assign shift_serial_out = shift_q[0];
  assign current_clock_sel_out = cur_sel_q;
  assign sequence_clock_sel_out = seq_sel_q;
  assign port_transfer_request_out = req_q;
  assign bus_request_level5_out = br5_q;

endmodule

`default_nettype wire

// [testbench/dcs_checker.sv]
// Port-level assertions for the disk sector check sequencer
`timescale 1ns/1ps
`default_nettype none
module dcs_checker (
  // Clock, reset and register bus
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [4:0] avs_address_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic avs_waitrequest_out,
  // Drive side and header search
  input wire logic sync_found_in,
  input wire logic tag_bus_bit1_out,
  input wire logic tag_line_three_out,
  input wire logic control_tag_strobe_out,
  input wire logic header_search_preset_out,
  input wire logic serializer_address_enable_out,
  input wire logic compare_load_strobe_out,
  // Clock control and CPU port
  input wire logic [1:0] current_clock_sel_out,
  input wire logic [1:0] sequence_clock_sel_out,
  input wire logic port_transfer_request_out,
  input wire logic bus_request_level5_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  logic grant_wr;
  assign grant_wr = avs_write_in && !avs_waitrequest_out &&
    avs_address_in == dcs_pkg::OFS_GRANT && avs_writedata_in[0];
  chk_tags_tied: assert property (
    tag_bus_bit1_out == tag_line_three_out &&
    tag_bus_bit1_out == control_tag_strobe_out) else $error("tags differ");
  chk_gate_servo: assert property (
    $rose(tag_bus_bit1_out) |-> current_clock_sel_out == 2'h1 &&
    sequence_clock_sel_out == 2'h1) else $error("gate off servo clock");
  chk_preset_gate: assert property (
    $rose(header_search_preset_out) |-> tag_bus_bit1_out)
    else $error("preset without read gate");
  chk_search_stall: assert property (
    header_search_preset_out |-> current_clock_sel_out == 2'h2 &&
    sequence_clock_sel_out == 2'h3) else $error("search clocks wrong");
  chk_seq_held: assert property (
    sequence_clock_sel_out == 2'h3 && !sync_found_in |=>
    sequence_clock_sel_out == 2'h3) else $error("sequence clock ran early");
  chk_load_cause: assert property (
    compare_load_strobe_out |-> $past(sync_found_in) ##1
    !compare_load_strobe_out) else $error("compare load out of turn");
  chk_addr_arm: assert property (
    serializer_address_enable_out |-> $past(header_search_preset_out) &&
    $past(sync_found_in)) else $error("serializer armed out of turn");
  chk_grant_clear: assert property (
    port_transfer_request_out && grant_wr |=> !port_transfer_request_out)
    else $error("grant left request up");
  chk_req_cpu_clk: assert property (
    port_transfer_request_out |-> current_clock_sel_out == 2'h0 &&
    sequence_clock_sel_out == 2'h0) else $error("request off cpu clock");
  chk_br5_idle: assert property (
    $rose(bus_request_level5_out) |-> !port_transfer_request_out &&
    sequence_clock_sel_out == 2'h0) else $error("level 5 mid function");
  cover property ($rose(tag_bus_bit1_out));
  cover property ($rose(compare_load_strobe_out));
  cover property ($rose(bus_request_level5_out));
endmodule
`default_nettype wire

// [testbench/dcs_drive_model.sv]
// Behavioural drive: free servo clock, framed read clock and data, marks
`timescale 1ns/1ps
`default_nettype none
module dcs_drive_model (
  // Drive pins toward the sequencer
  output logic servo_clock_out,
  output logic read_clock_out,
  output logic read_data_out,
  output logic sector_pulse_out,
  output logic index_pulse_out
);
  int rises = 0;
  initial {servo_clock_out, read_clock_out, read_data_out} = 3'h0;
  initial {sector_pulse_out, index_pulse_out} = 2'h0;
  always #400 servo_clock_out = ~servo_clock_out;
  always @(posedge servo_clock_out) rises <= rises + 1;
  // Mark raised mid-cycle so the first counted rise is unambiguous
  task automatic mark(input logic use_index);
    @(negedge servo_clock_out);
    rises = 0;
    if (use_index) index_pulse_out = 1'b1;
    else sector_pulse_out = 1'b1;
    #2400;
    {sector_pulse_out, index_pulse_out} = 2'h0;
  endtask
  // Clock stands still between frames; released data shows inverted
  task automatic send(input logic [31:0] d, input logic [15:0] c);
    #50;
    for (int i = 0; i < 48; i++) begin
      read_data_out = (i < 32) ? d[i] : c[47 - i];
      #400 read_clock_out = 1'b1;
      #400 read_clock_out = 1'b0;
    end
    read_data_out = ~read_data_out;
  endtask
endmodule
`default_nettype wire

// [testbench/dcs_sequencer_tb_top.sv]
// Self-checking bench for the disk sector check sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %0t %s", $time, m); end end
`define WAITC(c, n) begin k = 0; while (!(c) && k < n) begin \
  @(posedge mclk_in); k++; end if (!(c)) stuck(); end
module dcs_sequencer_tb_top;
  localparam int NB = 4;
  localparam logic [31:0] DATA = 32'h80c301a5;
  typedef struct packed {
    logic [2:0] fn;
    logic idx;
    logic [6:0] gap;
    logic [6:0] lock;
  } dcs_row_t;
  dcs_row_t rows [3] = '{'{3'h4, 1'b0, 7'h3c, 7'h58},
    '{3'h5, 1'b1, 7'h3c, 7'h58}, '{3'h6, 1'b0, 7'h3c, 7'h58}};
  int n_mismatch = 0;
  int n_tests = 0;
  int k, r0;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic sync_found_in = 1'b0;
  logic drive_ready_in = 1'b0;
  logic [4:0] avs_address_in = 5'h00;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] rd, avs_readdata_out;
  logic [1:0] current_clock_sel_out, sequence_clock_sel_out;
  logic avs_waitrequest_out, servo_clock_in, drive_read_clock_in;
  logic serial_read_stream_in, drive_sector_pulse_in, drive_index_pulse_in;
  logic tag_bus_bit1_out, tag_line_three_out, control_tag_strobe_out;
  logic header_search_preset_out, serializer_address_enable_out;
  logic shift_serial_out, compare_load_strobe_out;
  logic port_transfer_request_out, bus_request_level5_out;
  always #50 mclk_in = ~mclk_in;
  dcs_drive_model drv (.servo_clock_out(servo_clock_in),
    .read_clock_out(drive_read_clock_in),
    .read_data_out(serial_read_stream_in),
    .sector_pulse_out(drive_sector_pulse_in),
    .index_pulse_out(drive_index_pulse_in));
  dcs_sequencer #(.BYTES(NB)) dut (.mclk_in, .rst_in, .avs_address_in,
    .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out,
    .avs_waitrequest_out, .servo_clock_in, .drive_read_clock_in,
    .serial_read_stream_in, .drive_sector_pulse_in, .drive_index_pulse_in,
    .drive_ready_in, .tag_bus_bit1_out, .tag_line_three_out,
    .control_tag_strobe_out, .sync_found_in, .header_search_preset_out,
    .serializer_address_enable_out, .shift_serial_out,
    .compare_load_strobe_out, .current_clock_sel_out,
    .sequence_clock_sel_out, .port_transfer_request_out,
    .bus_request_level5_out);
  task automatic complete_run;
    $display("compares %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic stuck;
    n_mismatch++;
    $display("BAD %0t wait ran out", $time);
    complete_run();
  endtask
  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_read_in <= ~w;
    avs_write_in <= w;
    @(posedge mclk_in);
    `WAITC(avs_waitrequest_out === 1'b0, 50)
    rd = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask
  task automatic status;
    bus(1'b0, dcs_pkg::OFS_STATUS, 32'h0);
  endtask
  task automatic do_reset;
    rst_in <= 1'b1;
    repeat (12) @(posedge mclk_in);
    rst_in <= 1'b0;
  endtask
  function automatic logic [15:0] crc_of(input logic [31:0] v);
    logic [15:0] c;
    c = dcs_pkg::RST_CRC;
    for (int i = 0; i < NB * 8; i++)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? dcs_pkg::CRC_POLY : 16'h0);
    return c;
  endfunction
  // Sync found restarts the stalled sequence clock and loads byte 0
  task automatic sector(input logic [31:0] d, input logic [15:0] c);
    `WAITC(sequence_clock_sel_out === 2'h3, 3000)
    `CHK(current_clock_sel_out, 2'h2, "search clock")
    sync_found_in <= 1'b1;
    @(posedge mclk_in);
    sync_found_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    `CHK(shift_serial_out, DATA[0], "first bit")
    drv.send(d, c);
  endtask
  initial begin
    foreach (rows[r]) begin
      drive_ready_in <= 1'b0;
      do_reset();
      bus(1'b1, dcs_pkg::OFS_CONTROL, {29'h0, rows[r].fn});
      repeat (20) @(posedge mclk_in);
      `CHK(current_clock_sel_out, 2'h0, "no drive")
      drive_ready_in <= 1'b1;
      `WAITC(current_clock_sel_out === 2'h1, 20)
      `CHK(sequence_clock_sel_out, 2'h1, "servo")
      drv.mark(rows[r].idx);
      `WAITC(tag_bus_bit1_out === 1'b1, 2000)
      r0 = drv.rises;
      `CHK(r0, int'(rows[r].gap), "glitch wait")
      `WAITC(header_search_preset_out === 1'b1, 3000)
      `CHK(drv.rises - r0, int'(rows[r].lock), "lock wait")
      status();
      `CHK(rd[dcs_pkg::ST_MATCH_BIT], 1'b0, "match clear")
      sync_found_in <= 1'b1;
      @(posedge mclk_in);
      sync_found_in <= 1'b0;
      `WAITC(serializer_address_enable_out === 1'b1, 4)
      $display("fixed row %0d done", r);
    end
    do_reset();
    status();
    `CHK(rd[dcs_pkg::ST_READY_BIT], dcs_pkg::RST_READY, "reset ready")
    bus(1'b0, 5'h18, 32'h0);
    `CHK(rd, 32'h0, "unmapped read")
    for (int i = 0; i < 2 * NB; i++)
      bus(1'b1, dcs_pkg::OFS_BUFFER,
        {15'h0, i >= NB, 8'(i % NB), DATA[8 * (i % NB) +: 8]});
    bus(1'b1, dcs_pkg::OFS_CONTROL, 32'h41);
    sector(DATA, crc_of(DATA));
    `WAITC(port_transfer_request_out === 1'b1, 200)
    status();
    `CHK(rd[5:0], 6'h05, "clean sector")
    bus(1'b1, dcs_pkg::OFS_GRANT, 32'h1);
    status();
    `CHK(rd[5:0], 6'h09, "buffer swap")
    bus(1'b0, dcs_pkg::OFS_DISK_ADDR, 32'h0);
    `CHK(rd, 32'h1, "next sector")
    sector(DATA ^ 32'h100, crc_of(DATA));
    `WAITC(port_transfer_request_out === 1'b1, 200)
    status();
    `CHK(rd[5:0], 6'h0c, "mismatch only")
    bus(1'b1, dcs_pkg::OFS_CONTROL, 32'hc1);
    bus(1'b1, dcs_pkg::OFS_GRANT, 32'h1);
    `WAITC(bus_request_level5_out === 1'b1, 20)
    status();
    `CHK(rd[5:0], 6'h30, "stopped")
    $display("write check stop done");
    bus(1'b1, dcs_pkg::OFS_CONTROL, 32'h01);
    sector(DATA, crc_of(DATA) ^ 16'h8000);
    `WAITC(current_clock_sel_out === 2'h0, 50)
    status();
    `CHK(rd[5:0], 6'h23, "crc error")
    bus(1'b1, dcs_pkg::OFS_CONTROL, 32'h06);
    drv.mark(1'b0);
    `WAITC(tag_bus_bit1_out === 1'b1, 2000)
    status();
    `CHK(rd[0], 1'b0, "match cleared")
    $display("write check crc error done");
    complete_run();
  end
endmodule
bind dcs_sequencer dcs_checker u_chk (.mclk_in, .rst_in, .avs_address_in,
  .avs_write_in, .avs_writedata_in, .avs_waitrequest_out, .sync_found_in,
  .tag_bus_bit1_out, .tag_line_three_out, .control_tag_strobe_out,
  .header_search_preset_out, .serializer_address_enable_out,
  .compare_load_strobe_out, .current_clock_sel_out, .sequence_clock_sel_out,
  .port_transfer_request_out, .bus_request_level5_out);
`default_nettype wire
